/* File: rtl/tum_cfg.svh */
// Offsets, field positions, reset values and fixed words of the trace unit management registers.
// Assumes a 12-bit byte address on the register port; every register is one aligned 32-bit word.
`ifndef TUM_CFG_SVH
`define TUM_CFG_SVH

`define TUM_OFS_PD_STATUS     12'h314
`define TUM_OFS_CLAIM_SET     12'hfa0
`define TUM_OFS_CLAIM_CLEAR   12'hfa4
`define TUM_OFS_AFFINITY      12'hfa8
`define TUM_OFS_LOCK_KEY      12'hfb0
`define TUM_OFS_LOCK_STATUS   12'hfb4
`define TUM_OFS_AUTH_STATUS   12'hfb8
`define TUM_OFS_ARCH_ID       12'hfbc
`define TUM_OFS_CAPABILITY    12'hfc8
`define TUM_OFS_COMP_TYPE     12'hfcc

`define TUM_CLAIM_BITS        4
`define TUM_CLAIM_IMPL        4'hf
`define TUM_CLAIM_RESET       4'h0
`define TUM_LOCK_KEY_VALUE    32'hc5acce55
`define TUM_LOCK_RESET        1'b1
`define TUM_STICKY_RESET      1'b1

`define TUM_AFF_NEW_FORMAT    31
`define TUM_AFF_UNIPROC       30
`define TUM_AFF_CLUSTER_LSB   8
`define TUM_AFF_CORE_LSB      0

`define TUM_LSR_PRESENT       0
`define TUM_LSR_SET           1
`define TUM_LSR_WIDTH_FLAG    2

`define TUM_AUTH_SEC_NONINV_LSB 6
`define TUM_AUTH_SEC_INV_LSB  4
`define TUM_AUTH_IMPL_OFF     2'h2
`define TUM_AUTH_IMPL_ON      2'h3

`define TUM_PD_POWERED_UP     0
`define TUM_PD_STICKY         1

`define TUM_COMP_TYPE_VALUE   32'h00000013
`define TUM_CAPABILITY_VALUE  32'h00000000

`endif

/* File: rtl/tum_pkg.sv */
// Types shared by the trace unit management register bank.
// Assumes the constants of tum_cfg.svh for the widths.
`include "tum_cfg.svh"

package tum_pkg;
	typedef logic [11:0]                    tum_addr_t;
	typedef logic [31:0]                    tum_data_t;
	typedef logic [`TUM_CLAIM_BITS-1:0]     tum_claim_t;
endpackage

/* File: rtl/tum_mgmt_regs.sv */
// Management register group of a per-core trace unit: claim tag, software lock,
// power-down sticky flag and read-only identification and status words.
// Assumes a simple memory-mapped register port on clk_sys; pins are asynchronous to it.
//
// Behaviour
// - Claim-set reads return one for each implemented tag bit; upper bits zero.
// - Claim-set write sets each tag bit whose data bit is one.
// - Claim-clear reads return the present claim tag value.
// - Claim-clear write clears each tag bit whose data bit is one.
// - Affinity bit 31 always reads one.
// - Affinity bit 30 always reads zero.
// - Affinity bits 11:8 show the sampled cluster number inputs.
// - Affinity bits 1:0 give the served core number.
// - While locked, all writes except to the lock key register are dropped.
// - While locked, reading power-down status keeps its sticky flag.
// - Key value clears the lock; any other key write sets it.
// - Lock status bit 1 shows whether the lock is set.
// - Lock status bit 0 reads one, bit 2 reads zero.
// - Authentication bits 7:6 read 10 when disabled, 11 when enabled.
// - Authentication bits 5:4 read 10 when disabled, 11 when enabled.
// - Authentication bits 3:0 read zero.
// - Capability word reads all zeros.
// - Component type reads subtype 0001 and major type 0011.
// - Architecture register returns a fixed identification word.
`timescale 1ns/10ps
`include "tum_cfg.svh"

module tum_mgmt_regs #(
	// Arbitrary value, stands in for the architecture identification word
	parameter logic [31:0] ARCH_ID_VALUE = 32'h0000_0a5a
) (
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	input  wire tum_pkg::tum_addr_t reg_addr,
	input  wire logic              reg_write,
	input  wire logic              reg_read,
	input  wire tum_pkg::tum_data_t reg_wdata,
	output logic                   reg_rvalid,
	output tum_pkg::tum_data_t     reg_rdata,
	input  wire logic [3:0]        cluster_number_inputs,
	input  wire logic [1:0]        core_number_inputs,
	input  wire logic              secure_noninvasive_enable,
	input  wire logic              secure_invasive_enable,
	input  wire logic              powerdown_event,
	output logic                   lock_is_set
);
	import tum_pkg::*;

	// Two-flop synchronisers; only the second stage is read
	logic [8:0] pin_meta_r;
	logic [8:0] pin_sync_r;
	logic [8:0] pin_raw;

	assign pin_raw = {powerdown_event, secure_invasive_enable, secure_noninvasive_enable,
		core_number_inputs, cluster_number_inputs};

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pin_meta_r <= 9'h000;
			pin_sync_r <= 9'h000;
		end else begin
			pin_meta_r <= pin_raw;
			pin_sync_r <= pin_meta_r;
		end
	end

	logic [3:0] cluster_s;
	logic [1:0] core_s;
	logic       sec_noninv_en_s;
	logic       sec_inv_en_s;
	logic       pd_event_s;

	assign cluster_s  = pin_sync_r[3:0];
	assign core_s     = pin_sync_r[5:4];
	assign sec_noninv_en_s = pin_sync_r[6];
	assign sec_inv_en_s    = pin_sync_r[7];
	assign pd_event_s = pin_sync_r[8];

	// Write decode and power-down status read decode
	logic lock_r;
	logic wr_open;
	logic wr_key;
	logic wr_set;
	logic wr_clear;
	logic rd_pd;

	assign wr_key  = reg_write && (reg_addr == `TUM_OFS_LOCK_KEY);
	assign wr_open = reg_write && !lock_r;
	assign wr_set  = wr_open && (reg_addr == `TUM_OFS_CLAIM_SET);
	assign wr_clear = wr_open && (reg_addr == `TUM_OFS_CLAIM_CLEAR);
	assign rd_pd   = reg_read && (reg_addr == `TUM_OFS_PD_STATUS);

	// Software lock; set out of reset so a stray write cannot disturb the unit
	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			lock_r <= `TUM_LOCK_RESET;
		else if (wr_key)
			lock_r <= (reg_wdata != `TUM_LOCK_KEY_VALUE);
	end

	assign lock_is_set = lock_r;

	// Claim tag
	tum_claim_t claim_r;
	tum_claim_t claim_nxt;

	always_comb begin
		claim_nxt = claim_r;
		if (wr_set)
			claim_nxt = claim_nxt | reg_wdata[`TUM_CLAIM_BITS-1:0];
		if (wr_clear)
			claim_nxt = claim_nxt & ~reg_wdata[`TUM_CLAIM_BITS-1:0];
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			claim_r <= `TUM_CLAIM_RESET;
		else
			claim_r <= claim_nxt;
	end

	// Power-down sticky flag: a new event wins over the clear by read
	logic sticky_r;

	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			sticky_r <= `TUM_STICKY_RESET;
		else if (pd_event_s)
			sticky_r <= 1'b1;
		else if (rd_pd && !lock_r)
			sticky_r <= 1'b0;
	end

	// Read views
	tum_data_t aff_word;
	tum_data_t lsr_word;
	tum_data_t auth_word;
	tum_data_t pd_word;
	tum_data_t rd_mux;

	always_comb begin
		aff_word = 32'h0000_0000;
		aff_word[`TUM_AFF_NEW_FORMAT] = 1'b1;
		aff_word[`TUM_AFF_UNIPROC] = 1'b0;
		aff_word[`TUM_AFF_CLUSTER_LSB +: 4] = cluster_s;
		aff_word[`TUM_AFF_CORE_LSB +: 2] = core_s;

		lsr_word = 32'h0000_0000;
		lsr_word[`TUM_LSR_PRESENT] = 1'b1;
		lsr_word[`TUM_LSR_SET] = lock_r;
		lsr_word[`TUM_LSR_WIDTH_FLAG] = 1'b0;

		// Low four bits stay zero: no non-secure debug levels
		auth_word = 32'h0000_0000;
		auth_word[`TUM_AUTH_SEC_NONINV_LSB +: 2] = sec_noninv_en_s ? `TUM_AUTH_IMPL_ON : `TUM_AUTH_IMPL_OFF;
		auth_word[`TUM_AUTH_SEC_INV_LSB +: 2] = sec_inv_en_s ? `TUM_AUTH_IMPL_ON : `TUM_AUTH_IMPL_OFF;

		pd_word = 32'h0000_0000;
		pd_word[`TUM_PD_POWERED_UP] = 1'b1;
		pd_word[`TUM_PD_STICKY] = sticky_r;
	end

	// Read-only and unmapped words ignore writes; the write-only lock key and unmapped words read zero
	always_comb begin
		unique case (reg_addr)
			`TUM_OFS_CLAIM_SET:   rd_mux = {28'h0000000, `TUM_CLAIM_IMPL};
			`TUM_OFS_CLAIM_CLEAR: rd_mux = {28'h0000000, claim_r};
			`TUM_OFS_AFFINITY:    rd_mux = aff_word;
			`TUM_OFS_LOCK_STATUS: rd_mux = lsr_word;
			`TUM_OFS_AUTH_STATUS: rd_mux = auth_word;
			`TUM_OFS_ARCH_ID:     rd_mux = ARCH_ID_VALUE;
			`TUM_OFS_CAPABILITY:  rd_mux = `TUM_CAPABILITY_VALUE;
			`TUM_OFS_COMP_TYPE:   rd_mux = `TUM_COMP_TYPE_VALUE;
			`TUM_OFS_PD_STATUS:   rd_mux = pd_word;
			default:              rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data is registered; sticky value is sampled before its clear lands
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			reg_rvalid <= 1'b0;
			reg_rdata  <= 32'h0000_0000;
		end else begin
			reg_rvalid <= reg_read;
			if (reg_read)
				reg_rdata <= rd_mux;
		end
	end

endmodule

/* File: dv/tum_mgmt_checker.sv */
// Port assertions for the trace unit management register bank.
// Assumes one clk_sys domain and a synchronous active-low reset_n.
`timescale 1ns/10ps
module tum_mgmt_checker (
	input wire logic		clk_sys,
	input wire logic		reset_n,
	input wire tum_pkg::tum_addr_t	reg_addr,
	input wire logic		reg_write,
	input wire logic		reg_read,
	input wire tum_pkg::tum_data_t	reg_wdata,
	input wire logic		reg_rvalid,
	input wire tum_pkg::tum_data_t	reg_rdata,
	input wire logic		lock_is_set
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence s_rd(a);
		reg_read && reg_addr == a;
	endsequence
	sequence s_key(ok);
		reg_write && reg_addr == 12'hfb0 && ((reg_wdata == 32'hc5acce55) == ok);
	endsequence
	AST_RVALID: assert property (reg_rvalid == $past(reg_read)) else $error("rvalid timing");
	AST_CLAIM_SET_RD: assert property (s_rd(12'hfa0) |=> reg_rdata == 32'hf) else $error("claim set");
	AST_AFF_FMT: assert property (s_rd(12'hfa8) |=> reg_rdata[31:30] == 2'h2) else $error("affinity");
	AST_KEY_OK: assert property (s_key(1'h1) |=> !lock_is_set) else $error("unlock");
	AST_KEY_BAD: assert property (s_key(1'h0) |=> lock_is_set) else $error("relock");
	AST_LOCK_STEADY: assert property (!(reg_write && reg_addr == 12'hfb0) |=> $stable(lock_is_set))
		else $error("lock moved");
	AST_LOCK_STATUS: assert property (s_rd(12'hfb4) |=> reg_rdata == {30'h0, $past(lock_is_set), 1'h1})
		else $error("lock status");
	AST_AUTH: assert property (s_rd(12'hfb8) |=> {reg_rdata[31:8], reg_rdata[7], reg_rdata[5],
		reg_rdata[3:0]} == {24'h0, 2'h3, 4'h0}) else $error("auth");
	AST_CAPABILITY: assert property (s_rd(12'hfc8) |=> reg_rdata == 32'h0) else $error("capability");
	AST_TYPE: assert property (s_rd(12'hfcc) |=> reg_rdata == 32'h13) else $error("type");
endmodule

bind tum_mgmt_regs tum_mgmt_checker u_chk (.clk_sys, .reset_n, .reg_addr, .reg_write, .reg_read,
	.reg_wdata, .reg_rvalid, .reg_rdata, .lock_is_set);

/* File: dv/tb_top.sv */
// Self-checking bench for the trace unit management register bank.
// Assumes the checker is bound by its own file; inputs change at falling edges.
`timescale 1ns/10ps
module tb_top;
	logic			clk_sys, reset_n, reg_write, reg_read, reg_rvalid, lock_is_set;
	logic			secure_noninvasive_enable, secure_invasive_enable, powerdown_event;
	logic [3:0]		cluster_number_inputs;
	logic [1:0]		core_number_inputs;
	tum_pkg::tum_addr_t	reg_addr;
	tum_pkg::tum_data_t	reg_wdata, reg_rdata;
	int			n_mismatch = 0;
	int			n_tests = 0;
	tum_mgmt_regs #(.ARCH_ID_VALUE(32'h0000_1234)) u_dut (.clk_sys, .reset_n, .reg_addr, .reg_write,
		.reg_read, .reg_wdata, .reg_rvalid, .reg_rdata, .cluster_number_inputs, .core_number_inputs,
		.secure_noninvasive_enable, .secure_invasive_enable, .powerdown_event, .lock_is_set);
	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic results;
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'h1;
		@(negedge clk_sys);
		reg_write = 1'h0;
	endtask
	// Read answer is fixed at one cycle, so no wait loop is needed
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		@(negedge clk_sys);
		reg_addr = a;
		reg_read = 1'h1;
		@(negedge clk_sys);
		reg_read = 1'h0;
		chk("rvalid", {31'h0, reg_rvalid}, 32'h1);
		chk($sformatf("reg %h", a), reg_rdata, e);
	endtask
	initial begin
		#20us;
		n_mismatch++;
		results();
	end
	initial begin
		reset_n = 1'h0;
		reg_write = 1'h0;
		reg_read = 1'h0;
		reg_addr = 12'h0;
		reg_wdata = 32'h0;
		cluster_number_inputs = 4'ha;
		core_number_inputs = 2'h2;
		secure_noninvasive_enable = 1'h0;
		secure_invasive_enable = 1'h0;
		powerdown_event = 1'h0;
		repeat (8) @(negedge clk_sys);
		reset_n = 1'h1;
		chk("lock", {31'h0, lock_is_set}, 32'h1);
		rc(12'hfb4, 32'h3);
		rc(12'hfa4, 32'h0);
		rc(12'h314, 32'h3);
		rc(12'h314, 32'h3);
		wr(12'hfa0, 32'hf);
		rc(12'hfa4, 32'h0);
		wr(12'hfb0, 32'hc5acce55);
		rc(12'hfb4, 32'h1);
		rc(12'h314, 32'h3);
		rc(12'h314, 32'h1);
		powerdown_event = 1'h1;
		repeat (4) @(negedge clk_sys);
		powerdown_event = 1'h0;
		rc(12'h314, 32'h3);
		wr(12'hfa0, 32'hffff_fff5);
		rc(12'hfa4, 32'h5);
		wr(12'hfa0, 32'h2);
		rc(12'hfa4, 32'h7);
		wr(12'hfa4, 32'h6);
		rc(12'hfa4, 32'h1);
		rc(12'hfa0, 32'hf);
		wr(12'hfcc, 32'hffff_ffff);
		wr(12'hfc8, 32'hffff_ffff);
		wr(12'hfa8, 32'hffff_ffff);
		rc(12'hfa8, 32'h8000_0a02);
		rc(12'hfbc, 32'h0000_1234);
		rc(12'hfc8, 32'h0);
		rc(12'hfcc, 32'h13);
		rc(12'h100, 32'h0);
		for (int i = 0; i < 4; i++) begin
			{secure_noninvasive_enable, secure_invasive_enable} = i[1:0];
			repeat (3) @(negedge clk_sys);
			rc(12'hfb8, {24'h0, 1'h1, i[1], 1'h1, i[0], 4'h0});
		end
		wr(12'hfb0, 32'hc5acce54);
		rc(12'hfb4, 32'h3);
		wr(12'hfa4, 32'hf);
		rc(12'hfa4, 32'h1);
		reset_n = 1'h0;
		repeat (2) @(negedge clk_sys);
		reset_n = 1'h1;
		rc(12'hfa4, 32'h0);
		results();
	end
endmodule
